// File: logic/tw_defines.svh
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH
// What this block does
// - two-bit size field selects zero to three internal address bytes
// - direction bit 0 runs a write, 1 runs a read
// - programmed slave address picks the accessed slave
// - internal address bytes come from the internal address register
// - serial clock low lasts (low divider << exponent) + 3 cycles
// - serial clock high lasts (high divider << exponent) + 3 cycles once the synchronised clock reads high
// - exponent scales both dividers by a power of two
// - transfer complete stays 0 throughout a frame unless master enable is written mid-frame
// - transfer complete sets after the STOP and when master enabled
// - receive ready sets when a byte lands in receive holding
// - writing transmit holding clears transmit ready
// - transmit ready sets on shifter load, missing acknowledge, master enable
// - overrun sets on reload while receive ready; status read with complete clears
// - empty holding at shifter load sets underrun and forces STOP
// - missing acknowledge sets ack error with complete; status read clears
// - interrupt enable write of 1 sets the mask bit
// - interrupt disable write of 1 clears the mask bit
// - interrupt mask read shows enabled sources
// - received byte sits in the low eight bits of receive holding
// - byte to send is taken from the low eight bits of transmit holding
// - START is followed by seven-bit slave address and direction bit
// - reading receive holding clears receive ready

// register offsets
`define TW_OFS_CTRL      8'h00
`define TW_OFS_MODE      8'h04
`define TW_OFS_INT_ADDR_BYTES      8'h0C
`define TW_OFS_CWG       8'h10
`define TW_OFS_STATUS    8'h20
`define TW_OFS_IEN       8'h24
`define TW_OFS_IDIS      8'h28
`define TW_OFS_IMASK     8'h2C
`define TW_OFS_RXH       8'h30
`define TW_OFS_TXH       8'h34
// control bits
`define TW_CTRL_START    0
`define TW_CTRL_STOP     1
`define TW_CTRL_MASTER_ENABLE     2
`define TW_CTRL_MSDIS    3
// mode and waveform fields
`define TW_MODE_SZ_LSB   8
`define TW_MODE_DIR      12
`define TW_MODE_SLAVE_ADDRESS_LSB 16
`define TW_CWG_LO_LSB    0
`define TW_CWG_HI_LSB    8
`define TW_CWG_EXP_LSB   16
// status layout
`define TW_SR_TRANSFER_COMPLETE     0
`define TW_SR_RECEIVE_READY      1
`define TW_SR_TRANSMIT_READY      2
`define TW_SR_OVERRUN_FLAG       6
`define TW_SR_UNDERRUN_FLAG       7
`define TW_SR_ACK_ERROR       8
`define TW_SR_MASK       9'h1C7
// timing and framing
`define TW_EXTRA_CYCLES  16'h0003
`define TW_ACK_BIT       4'h8
`endif

// File: logic/tw_pkg.sv
package tw_pkg;
  // bus engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH,
    ST_RS_LOW, ST_RS_HIGH, ST_STOP_LOW, ST_STOP_HIGH
  } tw_state_type;
  // kind of byte on the wire
  typedef enum logic [1:0] {K_ADDR, K_INT_ADDR_BYTES, K_WDATA, K_RDATA} tw_kind_type;
endpackage

// File: logic/tw_master.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "tw_defines.svh"
module tw_master
  import tw_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // two-wire pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  ////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  function automatic logic [15:0] period(input logic [7:0] d, input logic [2:0] e);
    period = (16'({8'h00, d}) << e) + `TW_EXTRA_CYCLES;
  endfunction
  function automatic logic [7:0] pick(input logic [23:0] v, input logic [1:0] i);
    pick = v[{i, 3'b000} +: 8];
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////
  logic        scl_meta_reg, scl_s_reg, sda_meta_reg, sda_s_reg;
  logic [1:0]  sz_reg;
  logic        dir_reg;
  logic [6:0]  slave_address_reg;
  logic [23:0] int_addr_bytes_reg;
  logic [7:0]  lodiv_reg, hidiv_reg, thr_reg, rhr_reg;
  logic [2:0]  exp_reg;
  logic [8:0]  mask_reg;
  logic        en_reg, stop_req_reg, ack_error_pend_reg, restarted_reg;
  logic        transfer_complete_reg, receive_ready_reg, transmit_ready_reg, overrun_flag_reg, underrun_flag_reg, ack_error_reg;
  tw_state_type state_reg;
  tw_kind_type  kind_reg;
  logic [15:0] tick_reg, lo_cnt, hi_cnt;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [1:0]  left_reg;
  logic        wr_ctrl, ev_master_enable, ev_start, t_zero, byte_end, ack_error_seen;
  logic        go_int_addr_bytes, go_rdata, go_wdata, go_restart, go_stop;
  logic        ev_load, ev_underrun_flag, ev_rx, stop_done, sr_rd, drive_bit;
  logic [31:0] sr_vec, rd_mux;
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg    <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg    <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_s_reg    <= scl_meta_reg;
      sda_meta_reg <= sda_i;
      sda_s_reg    <= sda_meta_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // strobes and events
  assign wr_ctrl  = wr_i && hit(addr_i, `TW_OFS_CTRL);
  assign ev_master_enable  = wr_ctrl && wdata_i[`TW_CTRL_MASTER_ENABLE] && !wdata_i[`TW_CTRL_MSDIS];
  assign sr_rd    = rd_i && hit(addr_i, `TW_OFS_STATUS);
  // write frames start on holding write
  assign ev_start = (state_reg == ST_IDLE) && en_reg && ((wr_ctrl && wdata_i[`TW_CTRL_START])
                    || (wr_i && hit(addr_i, `TW_OFS_TXH) && !dir_reg));
  assign lo_cnt   = period(lodiv_reg, exp_reg) - 16'h0001;
  assign hi_cnt   = period(hidiv_reg, exp_reg) - 16'h0001;
  assign t_zero   = (tick_reg == 16'h0000);
  assign byte_end = (state_reg == ST_HIGH) && t_zero && scl_s_reg && (bit_cnt_reg == `TW_ACK_BIT);
  assign ack_error_seen = byte_end && (kind_reg != K_RDATA) && sda_s_reg;
  assign stop_done = (state_reg == ST_STOP_HIGH) && t_zero && scl_s_reg;
  assign ev_rx    = byte_end && (kind_reg == K_RDATA);
  assign ev_load  = byte_end && !ack_error_seen && go_wdata && !transmit_ready_reg;
  assign ev_underrun_flag  = byte_end && !ack_error_seen && go_wdata && transmit_ready_reg;
  assign go_stop  = ack_error_seen || ev_underrun_flag || !(go_int_addr_bytes || go_rdata || go_wdata || go_restart);
  // next byte after an acknowledged one
  always_comb begin
    go_int_addr_bytes    = 1'b0;
    go_rdata   = 1'b0;
    go_wdata   = 1'b0;
    go_restart = 1'b0;
    case (kind_reg)
      K_ADDR: begin
        if (sz_reg != 2'b00 && !restarted_reg) go_int_addr_bytes = 1'b1;
        else if (dir_reg) go_rdata = 1'b1;
        else go_wdata = 1'b1;
      end
      K_INT_ADDR_BYTES: begin
        if (left_reg != 2'b00) go_int_addr_bytes = 1'b1;
        else if (dir_reg) go_restart = 1'b1;
        else go_wdata = 1'b1;
      end
      K_WDATA: go_wdata = !stop_req_reg;
      default: go_rdata = !stop_req_reg;
    endcase
  end
  // level the data line is pulled to in a low phase
  always_comb begin
    if (bit_cnt_reg == `TW_ACK_BIT) drive_bit = (kind_reg == K_RDATA) && !stop_req_reg;
    else drive_bit = (kind_reg != K_RDATA) && !shift_reg[7];
  end
  ////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sz_reg    <= 2'b00;
      dir_reg   <= 1'b0;
      slave_address_reg  <= 7'h00;
      int_addr_bytes_reg  <= 24'h000000;
      lodiv_reg <= 8'h00;
      hidiv_reg <= 8'h00;
      exp_reg   <= 3'h0;
      thr_reg   <= 8'h00;
    end else if (wr_i) begin
      if (hit(addr_i, `TW_OFS_MODE)) begin
        sz_reg   <= wdata_i[`TW_MODE_SZ_LSB +: 2];
        dir_reg  <= wdata_i[`TW_MODE_DIR];
        slave_address_reg <= wdata_i[`TW_MODE_SLAVE_ADDRESS_LSB +: 7];
      end
      if (hit(addr_i, `TW_OFS_INT_ADDR_BYTES)) int_addr_bytes_reg <= wdata_i[23:0];
      if (hit(addr_i, `TW_OFS_CWG)) begin
        lodiv_reg <= wdata_i[`TW_CWG_LO_LSB +: 8];
        hidiv_reg <= wdata_i[`TW_CWG_HI_LSB +: 8];
        exp_reg   <= wdata_i[`TW_CWG_EXP_LSB +: 3];
      end
      if (hit(addr_i, `TW_OFS_TXH)) thr_reg <= wdata_i[7:0];
    end
  end
  // interrupt mask
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_reg <= 9'h000;
    end else if (wr_i) begin
      if (hit(addr_i, `TW_OFS_IEN)) mask_reg <= mask_reg | (wdata_i[8:0] & `TW_SR_MASK);
      if (hit(addr_i, `TW_OFS_IDIS)) mask_reg <= mask_reg & ~(wdata_i[8:0] & `TW_SR_MASK);
    end
  end
  // master enable and stop request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_reg       <= 1'b0;
      stop_req_reg <= 1'b0;
    end else begin
      if (ev_master_enable) en_reg <= 1'b1;
      else if (wr_ctrl && wdata_i[`TW_CTRL_MSDIS]) en_reg <= 1'b0;
      if (ev_start) stop_req_reg <= wr_ctrl && wdata_i[`TW_CTRL_STOP];
      else if (wr_ctrl && wdata_i[`TW_CTRL_STOP]) stop_req_reg <= 1'b1;
      else if (stop_done) stop_req_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // bus engine
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg     <= ST_IDLE;
      kind_reg      <= K_ADDR;
      tick_reg      <= 16'h0000;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      left_reg      <= 2'b00;
      restarted_reg <= 1'b0;
      ack_error_pend_reg <= 1'b0;
      scl_oe_o      <= 1'b0;
      sda_oe_o      <= 1'b0;
    end else begin
      // high phases wait for the line to be released
      if (!t_zero && (state_reg != ST_HIGH || scl_s_reg)) tick_reg <= tick_reg - 16'h0001;
      case (state_reg)
        ST_IDLE: begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          if (ev_start) begin
            state_reg     <= ST_START;
            sda_oe_o      <= 1'b1;
            tick_reg      <= hi_cnt;
            restarted_reg <= 1'b0;
            ack_error_pend_reg <= 1'b0;
          end
        end
        ST_START: if (t_zero) begin
          state_reg   <= ST_LOW;
          scl_oe_o    <= 1'b1;
          tick_reg    <= lo_cnt;
          kind_reg    <= K_ADDR;
          bit_cnt_reg <= 4'h0;
          shift_reg   <= {slave_address_reg, dir_reg && (sz_reg == 2'b00 || restarted_reg)};
        end
        ST_LOW: begin
          sda_oe_o <= drive_bit;
          if (t_zero) begin
            state_reg <= ST_HIGH;
            scl_oe_o  <= 1'b0;
            tick_reg  <= hi_cnt;
          end
        end
        ST_HIGH: if (t_zero && scl_s_reg) begin
          scl_oe_o <= 1'b1;
          tick_reg <= lo_cnt;
          if (bit_cnt_reg != `TW_ACK_BIT) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= {shift_reg[6:0], sda_s_reg};
            state_reg   <= ST_LOW;
          end else if (go_stop) begin
            ack_error_pend_reg <= ack_error_seen;
            state_reg     <= ST_STOP_LOW;
          end else if (go_restart) begin
            state_reg     <= ST_RS_LOW;
            restarted_reg <= 1'b1;
          end else begin
            state_reg   <= ST_LOW;
            bit_cnt_reg <= 4'h0;
            if (go_int_addr_bytes) begin
              // internal address bytes, high byte first
              kind_reg  <= K_INT_ADDR_BYTES;
              left_reg  <= (kind_reg == K_ADDR) ? sz_reg - 2'b01 : left_reg - 2'b01;
              shift_reg <= pick(int_addr_bytes_reg, (kind_reg == K_ADDR) ? sz_reg - 2'b01
                                                                  : left_reg - 2'b01);
            end else if (go_rdata) begin
              kind_reg <= K_RDATA;
            end else begin
              kind_reg  <= K_WDATA;
              shift_reg <= thr_reg;
            end
          end
        end
        ST_RS_LOW: begin
          sda_oe_o <= 1'b0;
          if (t_zero) begin
            state_reg <= ST_RS_HIGH;
            scl_oe_o  <= 1'b0;
            tick_reg  <= hi_cnt;
          end
        end
        ST_RS_HIGH: if (t_zero && scl_s_reg) begin
          state_reg <= ST_START;
          sda_oe_o  <= 1'b1;
          tick_reg  <= hi_cnt;
        end
        ST_STOP_LOW: begin
          sda_oe_o <= 1'b1;
          if (t_zero) begin
            state_reg <= ST_STOP_HIGH;
            scl_oe_o  <= 1'b0;
            tick_reg  <= hi_cnt;
          end
        end
        ST_STOP_HIGH: if (t_zero && scl_s_reg) begin
          state_reg <= ST_IDLE;
          sda_oe_o  <= 1'b0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // status flags, set wins over read clears
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      transfer_complete_reg <= 1'b1;
      receive_ready_reg  <= 1'b0;
      transmit_ready_reg  <= 1'b0;
      overrun_flag_reg   <= 1'b0;
      underrun_flag_reg   <= 1'b0;
      ack_error_reg   <= 1'b0;
      rhr_reg    <= 8'h00;
    end else begin
      if (ev_master_enable || stop_done) transfer_complete_reg <= 1'b1;
      else if (ev_start) transfer_complete_reg <= 1'b0;
      if (ev_rx) receive_ready_reg <= 1'b1;
      else if (rd_i && hit(addr_i, `TW_OFS_RXH)) receive_ready_reg <= 1'b0;
      if (ev_rx) rhr_reg <= shift_reg;
      // transmit ready, new data beats load
      if (wr_i && hit(addr_i, `TW_OFS_TXH)) transmit_ready_reg <= 1'b0;
      else if (ev_master_enable || ev_load || (stop_done && ack_error_pend_reg)) transmit_ready_reg <= 1'b1;
      if (ev_rx && receive_ready_reg) overrun_flag_reg <= 1'b1;
      else if (sr_rd && transfer_complete_reg) overrun_flag_reg <= 1'b0;
      if (ev_underrun_flag) underrun_flag_reg <= 1'b1;
      else if (sr_rd && transfer_complete_reg) underrun_flag_reg <= 1'b0;
      if (stop_done && ack_error_pend_reg) ack_error_reg <= 1'b1;
      else if (sr_rd) ack_error_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    sr_vec = 32'h00000000;
    sr_vec[`TW_SR_TRANSFER_COMPLETE] = transfer_complete_reg;
    sr_vec[`TW_SR_RECEIVE_READY]  = receive_ready_reg;
    sr_vec[`TW_SR_TRANSMIT_READY]  = transmit_ready_reg;
    sr_vec[`TW_SR_OVERRUN_FLAG]   = overrun_flag_reg;
    sr_vec[`TW_SR_UNDERRUN_FLAG]   = underrun_flag_reg;
    sr_vec[`TW_SR_ACK_ERROR]   = ack_error_reg;
    rd_mux = 32'h00000000;
    case (addr_i)
      `TW_OFS_MODE: begin
        rd_mux[`TW_MODE_SZ_LSB +: 2]   = sz_reg;
        rd_mux[`TW_MODE_DIR]           = dir_reg;
        rd_mux[`TW_MODE_SLAVE_ADDRESS_LSB +: 7] = slave_address_reg;
      end
      `TW_OFS_INT_ADDR_BYTES: rd_mux[23:0] = int_addr_bytes_reg;
      `TW_OFS_CWG: begin
        rd_mux[`TW_CWG_LO_LSB +: 8]  = lodiv_reg;
        rd_mux[`TW_CWG_HI_LSB +: 8]  = hidiv_reg;
        rd_mux[`TW_CWG_EXP_LSB +: 3] = exp_reg;
      end
      `TW_OFS_STATUS: rd_mux = sr_vec;
      `TW_OFS_IMASK: rd_mux[8:0] = mask_reg;
      `TW_OFS_RXH: rd_mux[7:0] = rhr_reg;
      `TW_OFS_TXH: rd_mux[7:0] = thr_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end
  // read data stands one cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
      scl_o   <= 1'b0;
      sda_o   <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h00000000;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  property p_thr_clr;
    wr_i && hit(addr_i, `TW_OFS_TXH) |=> !transmit_ready_reg;
  endproperty
  a_thr_clr: assert property (p_thr_clr) else $error("transmit_ready not cleared");
  property p_rhr_clr;
    rd_i && hit(addr_i, `TW_OFS_RXH) && !ev_rx |=> !receive_ready_reg;
  endproperty
  a_rhr_clr: assert property (p_rhr_clr) else $error("receive_ready not cleared");
  property p_ien;
    wr_i && hit(addr_i, `TW_OFS_IEN)
      |=> (mask_reg & $past(wdata_i[8:0]) & `TW_SR_MASK) == ($past(wdata_i[8:0]) & `TW_SR_MASK);
  endproperty
  a_ien: assert property (p_ien) else $error("enable bit not set");
  property p_idis;
    wr_i && hit(addr_i, `TW_OFS_IDIS) |=> (mask_reg & $past(wdata_i[8:0])) == 9'h000;
  endproperty
  a_idis: assert property (p_idis) else $error("disable bit not cleared");
  property p_imr;
    rd_i && hit(addr_i, `TW_OFS_IMASK) |=> rdata_o == {23'h000000, $past(mask_reg)};
  endproperty
  a_imr: assert property (p_imr) else $error("mask readback wrong");
  property p_busy;
    state_reg != ST_IDLE && !$past(ev_master_enable) |-> !transfer_complete_reg;
  endproperty
  a_busy: assert property (p_busy) else $error("complete set mid frame");
  property p_low;
    $rose(scl_oe_o) |-> tick_reg == lo_cnt;
  endproperty
  a_low: assert property (p_low) else $error("low phase length wrong");
  property p_master_enable;
    ev_master_enable && !(wr_i && hit(addr_i, `TW_OFS_TXH)) |=> transfer_complete_reg && transmit_ready_reg;
  endproperty
  a_master_enable: assert property (p_master_enable) else $error("enable flags not set");
  property p_overrun_flag;
    ev_rx && receive_ready_reg |=> overrun_flag_reg;
  endproperty
  a_overrun_flag: assert property (p_overrun_flag) else $error("overrun missed");
  c_rx: cover property (ev_rx);
  c_ack_error: cover property (stop_done && ack_error_pend_reg);
  c_restart: cover property (state_reg == ST_RS_HIGH);
endmodule // tw_master

// File: sim/tw_slave_model.sv
`timescale 1ns/1ns
module tw_slave_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // wire levels and behaviour
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [6:0]  addr_i,
  input  wire logic [7:0]  rd_byte_i,
  input  wire logic [3:0]  stretch_i,
  // pin pulls and received byte log
  output logic             scl_oe_o,
  output logic             sda_oe_o,
  output logic      [31:0] hist_o,
  output logic      [7:0]  nbytes_o
);
  logic       scl_reg;
  logic       sda_reg;
  logic       first_reg;
  logic       rd_reg;
  logic [3:0] cnt_reg;
  logic [3:0] st_reg;
  logic [7:0] sh_reg;
  logic       ack;

  ////////////////////////////////////////////////////////////////////////////
  // only the first byte is checked against our address
  assign ack      = first_reg ? (sh_reg[7:1] == addr_i) : 1'b1;
  assign scl_oe_o = (st_reg != 4'h0);

  // previous wire levels for edge detection
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
    end
  end

  // clock stretch: hold the clock low a while after each fall
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= 4'h0;
    end else if (scl_reg && !scl_i) begin
      st_reg <= stretch_i;
    end else if (st_reg != 4'h0) begin
      st_reg <= st_reg - 4'h1;
    end
  end

  // frame decoder: bits in on rise, ack and read bits out on fall
  // start, stop and byte decoding
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg   <= 4'hF;
      first_reg <= 1'b0;
      rd_reg    <= 1'b0;
      sda_oe_o  <= 1'b0;
      sh_reg    <= 8'h00;
      hist_o    <= 32'h0;
      nbytes_o  <= 8'h00;
    end else if (scl_i && scl_reg && (sda_reg != sda_i)) begin
      cnt_reg   <= 4'hF;
      first_reg <= !sda_i;
      rd_reg    <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (!scl_reg && scl_i) begin
      if (cnt_reg < 4'h8) begin
        sh_reg <= {sh_reg[6:0], sda_i};
      end else if (cnt_reg == 4'h8 && sda_i) begin
        rd_reg <= 1'b0;
      end
    end else if (scl_reg && !scl_i) begin
      case (cnt_reg)
        4'hF: begin
          cnt_reg <= 4'h0;
        end
        4'h7: begin
          cnt_reg   <= 4'h8;
          first_reg <= 1'b0;
          sda_oe_o  <= !rd_reg && ack;
          if (!rd_reg) begin
            hist_o   <= {hist_o[23:0], sh_reg};
            nbytes_o <= nbytes_o + 8'h01;
          end
          if (first_reg) begin
            rd_reg <= ack && sh_reg[0];
          end
        end
        4'h8: begin
          cnt_reg  <= 4'h0;
          sda_oe_o <= rd_reg && !rd_byte_i[7];
        end
        default: begin
          cnt_reg  <= cnt_reg + 4'h1;
          sda_oe_o <= rd_reg && !rd_byte_i[3'(4'h6 - cnt_reg)];
        end
      endcase
    end
  end
endmodule // tw_slave_model

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } tw_row_type;

  logic        clk_i;
  logic        reset_i;
  logic        wr_i;
  logic        rd_i;
  logic        scl_o;
  logic        sda_o;
  logic        scl_oe_o;
  logic        sda_oe_o;
  logic        s_scl_oe;
  logic        s_sda_oe;
  logic        scl_w;
  logic        sda_w;
  logic [7:0]  addr_i;
  logic [7:0]  nbytes;
  logic [7:0]  rd_byte;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [31:0] st;
  logic [31:0] hist;
  logic [3:0]  stretch;
  logic [7:0]  lo_cnt;
  logic [7:0]  hi_cnt;
  logic [7:0]  last_lo;
  logic [7:0]  last_hi;
  int          failures;
  int          n_tests;
  tw_row_type  rows [17];

  ////////////////////////////////////////////////////////////////////////////
  // open-drain lines with pull-ups
  assign scl_w = !(scl_oe_o || s_scl_oe);
  assign sda_w = !(sda_oe_o || s_sda_oe);

  tw_master tw_master_i (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
  );

  tw_slave_model tw_slave_model_i (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w),
    .addr_i(7'h5A), .rd_byte_i(rd_byte), .stretch_i(stretch),
    .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .hist_o(hist), .nbytes_o(nbytes)
  );

  // clock generator
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = !clk_i;
  end

  // lengths of the last low and high clock phases
  always @(posedge clk_i) begin
    lo_cnt <= scl_oe_o ? lo_cnt + 8'h01 : 8'h00;
    hi_cnt <= scl_w ? hi_cnt + 8'h01 : 8'h00;
    if (!scl_oe_o && lo_cnt != 8'h00) last_lo <= lo_cnt;
    if (!scl_w && hi_cnt != 8'h00) last_hi <= hi_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // poll status until a bit reaches a value; st keeps the last read
  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 4000; i++) begin
      rd(8'h20, st);
      if (st[b] === v) return;
    end
    failures++;
    $display("CHECK FAILED at %0t: status wait timed out", $time);
    stop_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wdata_i, stretch} = {1'b1, 46'h0};
    {lo_cnt, hi_cnt, last_lo, last_hi, failures, n_tests} = '0;
    rd_byte = 8'hC6;
    rows = '{
      '{8'h08, 32'hFFFF_FFFF, 8'h04, 32'h0000_0000},
      '{8'h08, 32'hFFFF_FFFF, 8'h0C, 32'h0000_0000},
      '{8'h08, 32'hFFFF_FFFF, 8'h10, 32'h0000_0000},
      '{8'h08, 32'hFFFF_FFFF, 8'h20, 32'h0000_0001},
      '{8'h08, 32'hFFFF_FFFF, 8'h2C, 32'h0000_0000},
      '{8'h08, 32'hFFFF_FFFF, 8'h30, 32'h0000_0000},
      '{8'h08, 32'hFFFF_FFFF, 8'h08, 32'h0000_0000},
      '{8'h04, 32'hFFFF_FFFF, 8'h04, 32'h007F_1300},
      '{8'h0C, 32'hFFFF_FFFF, 8'h0C, 32'h00FF_FFFF},
      '{8'h10, 32'hFFFF_FFFF, 8'h10, 32'h0007_FFFF},
      '{8'h34, 32'h1234_56A5, 8'h34, 32'h0000_00A5},
      '{8'h20, 32'hFFFF_FFFF, 8'h20, 32'h0000_0001},
      '{8'h24, 32'h0000_01C7, 8'h2C, 32'h0000_01C7},
      '{8'h28, 32'h0000_0041, 8'h2C, 32'h0000_0186},
      '{8'h28, 32'h0000_0000, 8'h2C, 32'h0000_0186},
      '{8'h2C, 32'hFFFF_FFFF, 8'h2C, 32'h0000_0186},
      '{8'h24, 32'h0FFF_FFFF, 8'h2C, 32'h0000_01C7}};
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // register table walk
    foreach (rows[k]) begin
      wr(rows[k].wa, rows[k].wd);
      rd(rows[k].ra, st);
      chk(st, rows[k].ex);
    end
    // read data falls back to zero in the cycle after it stood
    @(posedge clk_i);
    #1 chk(rdata_o, 32'h0);
    // write frame, two internal bytes, then underrun ends it
    wr(8'h00, 32'h0000_0004);
    rd(8'h20, st);
    chk(st, 32'h0000_0005);
    wr(8'h10, 32'h0001_0102);
    wr(8'h0C, 32'h0012_3456);
    wr(8'h04, 32'h005A_0200);
    wr(8'h34, 32'h0000_0099);
    rd(8'h20, st);
    chk(st & 32'h5, 32'h0);
    poll(2, 1'b1);
    wr(8'h34, 32'h0000_0077);
    chk({24'h0, last_lo}, 32'h7);
    chk({31'h0, last_hi >= 8'h05 && last_hi <= 8'h07}, 32'h1);
    poll(0, 1'b1);
    chk(st & 32'h1C7, 32'h085);
    rd(8'h20, st);
    chk(st & 32'h1C7, 32'h005);
    chk(hist, 32'h3456_9977);
    chk({24'h0, nbytes}, 32'h5);
    // read frame with restart, slow slave, overrun, then stop
    stretch <= 4'hC;
    wr(8'h0C, 32'h0000_00E1);
    wr(8'h04, 32'h005A_1100);
    wr(8'h00, 32'h0000_0001);
    poll(6, 1'b1);
    wr(8'h00, 32'h0000_0002);
    poll(0, 1'b1);
    chk(st & 32'h1C3, 32'h043);
    rd(8'h30, st);
    chk(st, 32'h0000_00C6);
    rd(8'h20, st);
    chk(st & 32'h1C3, 32'h001);
    chk(hist & 32'h00FF_FFFF, 32'h00B4_E1B5);
    // absent slave leaves the address unacknowledged
    stretch <= 4'h0;
    wr(8'h04, 32'h0021_0000);
    wr(8'h34, 32'h0000_0011);
    poll(0, 1'b1);
    chk(st & 32'h1C7, 32'h105);
    rd(8'h20, st);
    chk(st & 32'h1C7, 32'h005);
    // reset in mid-frame returns pins and registers to idle
    wr(8'h04, 32'h005A_0000);
    wr(8'h34, 32'h0000_0042);
    poll(2, 1'b1);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({28'h0, scl_o, sda_o, scl_oe_o, sda_oe_o}, 32'h0);
    reset_i <= 1'b0;
    rd(8'h2C, st);
    chk(st, 32'h0);
    rd(8'h20, st);
    chk(st, 32'h1);
    stop_test();
  end
endmodule // tb_top
